/* core/adc_regs_pkg.sv */
package adc_regs_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h17;
  localparam logic [7:0] OFS_CONTROL = 8'h18;
  localparam logic [7:0] OFS_SELECT = 8'h19;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_START = 3;
  localparam int POS_NIBBLE_LO = 4;
  localparam int POS_REF_LO = 6;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_CLOCK_SELECT = 3'h0;
  localparam logic [1:0] RST_REFERENCE = 2'h0;
  localparam logic [4:0] RST_CHANNEL = 5'h1f;
  localparam logic [11:0] RST_RESULT = 12'h000;
  localparam logic [7:0] RST_DIVIDER = 8'h00;
  localparam logic [7:0] RDATA_IDLE = 8'h00;
  localparam logic [1:0] REF_RESERVED = 2'h2;
  // Widest conversion clock divider, system clock / 256
  localparam int DIV_MAX_LOG2 = 8;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BUSY = 2'b01
  } conv_state_type;
endpackage : adc_regs_pkg

/* core/adc_control_registers.sv */
// Contract
// - Result bits 11..4 read back as a read-only byte at 17h.
// - Result bits 3..0 read back in bits 7..4 of the control register at 18h.
// - Hardware clears the start bit when the conversion ends, so zero means done.
// - Control bits 2..0 divide the system clock by 256 down to 2 for codes 000 to 111.
// - Select bits 7..6 choose the reference, reset 00, and code 10 is reserved.
// - Select bits 4..0 choose the input channel, 0 is port A bit 0, reset 1F.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
module adc_control_registers (
  input wire logic sys_clk, // 40 MHz system clock
  input wire logic sys_rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register address
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic reg_write, // Write strobe
  input wire logic reg_read, // Read strobe
  output logic [7:0] reg_rdata, // Read data, one cycle after strobe
  output logic conv_start, // One-cycle start pulse to core
  output logic conv_clk_en, // Conversion clock enable pulse
  input wire logic conv_done, // Core end-of-conversion pulse
  input wire logic [11:0] conv_result, // Core result, valid with conv_done
  output logic [1:0] reference_select, // Reference choice to core
  output logic [4:0] input_channel_select // Channel choice to multiplexer
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic start_reg;
  logic [2:0] clock_select_reg;
  logic [1:0] reference_reg;
  logic [4:0] channel_reg;
  logic [11:0] result_reg;
  logic [7:0] rdata_reg;
  logic [7:0] div_reg;
  logic conv_start_reg;
  adc_regs_pkg::conv_state_type state_reg;
  adc_regs_pkg::conv_state_type state_next;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic wr_control = reg_write && (reg_addr == adc_regs_pkg::OFS_CONTROL);
  wire logic wr_select = reg_write && (reg_addr == adc_regs_pkg::OFS_SELECT);
  wire logic start_req = wr_control && reg_wdata[adc_regs_pkg::POS_START] && !start_reg;
  wire logic finish = (state_reg == adc_regs_pkg::ST_BUSY) && conv_done;
  wire logic [7:0] control_view = {result_reg[3:0], start_reg, clock_select_reg};
  wire logic [7:0] select_view = {reference_reg, 1'b0, channel_reg};
  logic [7:0] rdata_next;

  always_comb begin
    case (reg_addr)
      adc_regs_pkg::OFS_RESULT_HIGH: rdata_next = result_reg[11:4];
      adc_regs_pkg::OFS_CONTROL: rdata_next = control_view;
      adc_regs_pkg::OFS_SELECT: rdata_next = select_view;
      default: rdata_next = 8'h00;
    endcase
  end

  // Divider tap: code 0 -> /256 (bit 7 wrap), code 7 -> /2 (bit 0 wrap)
  function automatic logic div_tick(input logic [7:0] cnt, input logic [2:0] code);
    logic [7:0] mask;
    mask = 8'hff >> code;
    div_tick = ((cnt & mask) == mask);
  endfunction : div_tick

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      adc_regs_pkg::ST_IDLE: if (start_req) state_next = adc_regs_pkg::ST_BUSY;
      adc_regs_pkg::ST_BUSY: if (conv_done) state_next = adc_regs_pkg::ST_IDLE;
      default: state_next = adc_regs_pkg::ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Conversion state and the start bit
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_reg <= adc_regs_pkg::ST_IDLE;
      start_reg <= 1'b0;
      conv_start_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      conv_start_reg <= start_req;
      if (start_req) begin
        start_reg <= 1'b1;
      end else if (finish) begin
        start_reg <= 1'b0;
      end
    end
  end

  // Result holds until a completion loads all twelve bits at once
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      result_reg <= adc_regs_pkg::RST_RESULT;
    end else if (finish) begin
      result_reg <= conv_result;
    end
  end

  // Software selections, reserved reference code refused
  wire logic ref_reserved = (reg_wdata[7:6] == adc_regs_pkg::REF_RESERVED);
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      clock_select_reg <= adc_regs_pkg::RST_CLOCK_SELECT;
      reference_reg <= adc_regs_pkg::RST_REFERENCE;
      channel_reg <= adc_regs_pkg::RST_CHANNEL;
    end else begin
      if (wr_control) clock_select_reg <= reg_wdata[2:0];
      if (wr_select && !ref_reserved) reference_reg <= reg_wdata[7:6];
      if (wr_select) channel_reg <= reg_wdata[4:0];
    end
  end

  // Read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rdata_reg <= adc_regs_pkg::RDATA_IDLE;
    end else begin
      rdata_reg <= reg_read ? rdata_next : adc_regs_pkg::RDATA_IDLE;
    end
  end

  // Free-running divider, tapped by the clock select code
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      div_reg <= adc_regs_pkg::RST_DIVIDER;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  assign reg_rdata = rdata_reg;
  assign conv_start = conv_start_reg;
  assign conv_clk_en = div_tick(div_reg, clock_select_reg);
  assign reference_select = reference_reg;
  assign input_channel_select = channel_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_launch;
    reg_write && reg_addr == adc_regs_pkg::OFS_CONTROL && reg_wdata[3] && !start_reg;
  endsequence

  AST_START_SETS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_launch |=> start_reg && conv_start) else $error("start bit not set on launch");
  AST_START_CLEARS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start_reg && conv_done && state_reg == adc_regs_pkg::ST_BUSY) |=> !start_reg)
    else $error("start bit not cleared at completion");
  AST_RESULT_HOLD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !finish |=> $stable(result_reg)) else $error("result changed without completion");
  AST_RESULT_LOAD: assert property (@(posedge sys_clk) disable iff (sys_rst)
    finish |=> result_reg == $past(conv_result)) else $error("result not loaded");
  AST_HIGH_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr == adc_regs_pkg::OFS_RESULT_HIGH && !finish) |=> reg_rdata == result_reg[11:4])
    else $error("high byte read wrong");
  AST_NIBBLE_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr == adc_regs_pkg::OFS_CONTROL && !finish) |=> reg_rdata[7:4] == result_reg[3:0])
    else $error("low nibble read wrong");
  AST_REF_NO_RESERVED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    reference_select != adc_regs_pkg::REF_RESERVED) else $error("reserved reference code");
  AST_DIV2: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (clock_select_reg == 3'h7 && conv_clk_en) |=> !conv_clk_en ##1 conv_clk_en)
    else $error("divide by two wrong");
  AST_CHANNEL_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_select |=> input_channel_select == $past(reg_wdata[4:0])) else $error("channel not written");

  // ----------------------------------------------------------------
  // Handshake and bus checks
  // ----------------------------------------------------------------
  sequence s_finish;
    state_reg == adc_regs_pkg::ST_BUSY && conv_done;
  endsequence

  sequence s_refused_launch;
    reg_write && reg_addr == adc_regs_pkg::OFS_CONTROL && reg_wdata[3] && start_reg;
  endsequence

  AST_START_PULSE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    conv_start |=> !conv_start)
    else $error("start pulse longer than one cycle");
  AST_BUSY_NO_RELAUNCH: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_refused_launch |=> !conv_start)
    else $error("start accepted while busy");
  AST_START_HOLDS: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (start_reg && !finish) |=> start_reg)
    else $error("start bit dropped before completion");
  AST_FINISH_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_finish |=> state_reg == adc_regs_pkg::ST_IDLE && !start_reg)
    else $error("not idle after completion");
  AST_IDLE_DONE_IGNORED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (!start_reg && conv_done && !start_req) |=> !start_reg && $stable(result_reg))
    else $error("completion accepted while idle");
  AST_CONTROL_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_read && !reg_write && reg_addr == adc_regs_pkg::OFS_CONTROL && !finish) |=>
      reg_rdata[3:0] == {start_reg, clock_select_reg}) else $error("control read wrong");
  AST_CLKSEL_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    wr_control |=> clock_select_reg == $past(reg_wdata[2:0]))
    else $error("clock select not written");
  AST_EN_SPACED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (conv_clk_en && clock_select_reg != 3'h7 && !wr_control) |=> !conv_clk_en)
    else $error("clock enable pulses too close");
  AST_REF_WRITE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_select && !ref_reserved) |=> reference_select == $past(reg_wdata[7:6]))
    else $error("reference not written");
  AST_REF_REFUSED: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (wr_select && ref_reserved) |=> $stable(reference_select))
    else $error("reserved reference code stored");
  AST_SELECT_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_read && !reg_write && reg_addr == adc_regs_pkg::OFS_SELECT) |=>
      reg_rdata == {reference_select, 1'b0, input_channel_select}) else $error("select read wrong");
  AST_READ_IDLE: assert property (@(posedge sys_clk) disable iff (sys_rst)
    !reg_read |=> reg_rdata == adc_regs_pkg::RDATA_IDLE)
    else $error("read data outside its cycle");
  AST_UNMAPPED_READ: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (reg_read && reg_addr != adc_regs_pkg::OFS_RESULT_HIGH && reg_addr != adc_regs_pkg::OFS_CONTROL &&
      reg_addr != adc_regs_pkg::OFS_SELECT) |=> reg_rdata == adc_regs_pkg::RDATA_IDLE)
    else $error("unmapped read not zero");
endmodule : adc_control_registers

/* tb/adc_core_model.sv */
`timescale 1ns/100ps
module adc_core_model (
  input wire logic sys_clk, // System clock
  input wire logic conv_start, // Start pulse
  input wire logic conv_clk_en, // Conversion clock enable
  input wire logic [11:0] next_result, // Value of the next result
  output logic conv_done, // End of conversion pulse
  output logic [11:0] conv_result // Result, scrambled outside the done cycle
);
  int ticks = -1;
  initial conv_done = 1'b0;
  initial conv_result = 12'h000;
  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (conv_start) begin
      ticks <= 6;
    end else if (ticks == 0) begin
      conv_done <= 1'b1;
      conv_result <= next_result;
      ticks <= -1;
    end else if (ticks > 0 && conv_clk_en) begin
      ticks <= ticks - 1;
    end
  end
endmodule : adc_core_model

/* tb/tb_adc_control_registers.sv */
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_adc_control_registers;
  logic sys_clk = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0, conv_start, conv_clk_en, conv_done;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [11:0] conv_result, next_result = 12'ha5c;
  logic [1:0] reference_select;
  logic [4:0] input_channel_select;
  int fail_count = 0, total_checks = 0, cycles = 0, n, start_pulses = 0;
  logic [16:0] rows [12] = '{{1'b0, 16'h191f}, {1'b0, 16'h1800}, {1'b0, 16'h1700}, {1'b1, 16'h1945},
    {1'b0, 16'h1945}, {1'b1, 16'h19c0}, {1'b0, 16'h19c0}, {1'b1, 16'h199f}, {1'b0, 16'h19df},
    {1'b1, 16'h17ff}, {1'b0, 16'h1700}, {1'b0, 16'h2000}};
  always #12.5 sys_clk = ~sys_clk;
  adc_control_registers adc_control_registers_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .conv_start(conv_start), .conv_clk_en(conv_clk_en), .conv_done(conv_done), .conv_result(conv_result),
    .reference_select(reference_select), .input_channel_select(input_channel_select));
  adc_core_model adc_core_model_inst (.sys_clk(sys_clk), .conv_start(conv_start), .conv_clk_en(conv_clk_en),
    .next_result(next_result), .conv_done(conv_done), .conv_result(conv_result));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
    @(posedge sys_clk);
  endtask : rd
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      report_and_stop();
    end
  end
  // Counts start pulses seen by the core
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1) start_pulses++;
  end
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    @(posedge sys_clk);
    foreach (rows[i]) begin
      if (rows[i][16]) wr(rows[i][15:8], rows[i][7:0]);
      else rd(rows[i][15:8], rows[i][7:0]);
    end
    `CHK({reference_select, input_channel_select}, 7'h7f)
    wr(8'h18, 8'hf2);
    rd(8'h18, 8'h02);
    for (int c = 0; c < 8; c++) begin
      @(posedge sys_clk);
      wr(8'h18, {5'h00, c[2:0]});
      do begin @(posedge sys_clk); #1; end while (conv_clk_en !== 1'b1);
      n = 0;
      do begin @(posedge sys_clk); #1; n++; end while (conv_clk_en !== 1'b1);
      `CHK(n, 256 >> c)
    end
    @(posedge sys_clk);
    wr(8'h18, 8'h0b); // Divide by 32, near 1 MHz
    rd(8'h18, 8'h0b);
    rd(8'h17, 8'h00);
    wr(8'h18, 8'h0b); // Start again while busy, selection unchanged
    do begin @(posedge sys_clk); #1; end while (conv_done !== 1'b1);
    `CHK(start_pulses, 1)
    @(posedge sys_clk);
    rd(8'h17, 8'ha5);
    rd(8'h18, 8'hc3);
    next_result <= 12'h3c6;
    wr(8'h18, 8'h0b);
    rd(8'h18, 8'hcb);
    sys_rst <= 1'b1;
    @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(8'h19, 8'h1f);
    rd(8'h18, 8'h00);
    `CHK({reference_select, input_channel_select}, 7'h1f)
    do begin @(posedge sys_clk); #1; end while (conv_done !== 1'b1);
    @(posedge sys_clk);
    rd(8'h17, 8'h00);
    rd(8'h18, 8'h00);
    `CHK(start_pulses, 2)
    report_and_stop();
  end
endmodule : tb_adc_control_registers
